//--- common/wom_consts.vh
`ifndef WOM_CONSTS_VH
`define WOM_CONSTS_VH

// Register byte addresses
`define WOM_ADDR_FEAT_LO 12'h000
`define WOM_ADDR_FEAT_HI 12'h004
`define WOM_ADDR_RANGE0 12'h008
`define WOM_ADDR_RANGE1 12'h00c
`define WOM_ADDR_STATUS 12'h010

// Reset values
`define WOM_FEAT_RST 32'h00000000
`define WOM_RANGE_RST 32'h00000000

// Field positions
`define WOM_FEAT_GLOB 3
`define WOM_FEAT_SPEC 2
`define WOM_RNG_NOCACHE 0
`define WOM_RNG_COMB 1
`define WOM_RNG_MASK_HI 16
`define WOM_RNG_MASK_LO 2
`define WOM_RNG_BASE_HI 31
`define WOM_RNG_BASE_LO 17
`define WOM_A20_BIT 20

// Ordering modes
`define WOM_MODE_NONE 2'h0
`define WOM_MODE_SPEC 2'h1
`define WOM_MODE_FULL 2'h2

// Request kinds and line states
`define WOM_KIND_STORE 1'h0
`define WOM_KIND_WBACK 1'h1
`define WOM_MESI_I 2'h0
`define WOM_MESI_S 2'h1
`define WOM_MESI_E 2'h2
`define WOM_MESI_M 2'h3
`endif

//--- core/wom_ctrl.v
`timescale 1ns/1ps
`include "wom_consts.vh"
module wom_ctrl (
  input wire clock, // 125 MHz clock
  input wire sys_rst, // Synchronous reset, high
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg pready, // APB ready
  output reg [31:0] prdata, // APB read data
  output reg pslverr, // APB error, unmapped address
  input wire addr_bit20_mask_n, // Bit-20 mask pin, low active
  input wire ext_write_buf_empty_n, // Buffer-empty pin, low active
  input wire wr_valid, // Write request, held until done
  input wire wr_kind, // 0 store, 1 line writeback
  input wire [31:0] wr_addr, // Physical address
  input wire [63:0] wr_data, // Write data, 8 lanes
  input wire [7:0] wr_be, // Byte enables
  input wire wr_hit, // Store hits the cache
  input wire [1:0] wr_state, // Line state on hit
  output reg wr_done_r, // Request finished, one pulse
  output reg wr_held_r, // Commit waiting on buffer-empty
  output reg bus_req_r, // Bus write request
  output reg bus_burst_r, // Burst cycle when high
  output reg [31:0] bus_addr_r, // Bus address
  output reg [63:0] bus_data_r, // Bus data
  output reg [7:0] bus_be_r, // Bus byte enables
  input wire bus_ack, // Bus cycle done
  output reg cache_commit_r, // Cache update, one pulse
  output reg [31:0] cache_addr_r, // Cache update address
  output reg [63:0] cache_data_r, // Cache update data
  output reg [7:0] cache_be_r // Cache update byte enables
);

  localparam ST_IDLE = 2'h0;
  localparam ST_DECIDE = 2'h1;
  localparam ST_DRAIN = 2'h2;
  localparam ST_BUS = 2'h3;

  function rng_in;
    input [31:0] rng;
    input [31:0] addr;
    reg [14:0] msk;
    begin
      msk = rng[`WOM_RNG_MASK_HI:`WOM_RNG_MASK_LO];
      rng_in = (msk & rng[`WOM_RNG_BASE_HI:`WOM_RNG_BASE_LO]) == (msk & addr[31:17]);
    end
  endfunction

  function wb_line;
    input [1:0] st;
    begin
      wb_line = (st == `WOM_MESI_M) || (st == `WOM_MESI_E);
    end
  endfunction

  function [63:0] merge_bytes;
    input [63:0] old;
    input [63:0] nw;
    input [7:0] be;
    integer i;
    begin
      merge_bytes = old;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (be[i])
          merge_bytes[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  reg [31:0] feat_lo_r;
  reg [31:0] feat_hi_r;
  reg [31:0] rng0_r;
  reg [31:0] rng1_r;
  reg [2:0] a20_sy_r;
  reg [2:0] bufemp_sy_r;
  reg a20_act_r;
  reg bufemp_neg_r;
  reg [1:0] st_r;
  reg drain_ret_r;
  reg rq_kind_r;
  reg [31:0] rq_addr_r;
  reg [63:0] rq_data_r;
  reg [7:0] rq_be_r;
  reg rq_hit_r;
  reg [1:0] rq_state_r;
  reg mb_valid_r;
  reg [28:0] mb_addr_r;
  reg [63:0] mb_data_r;
  reg [7:0] mb_be_r;
  reg [31:0] rd_val;

  // Ordering mode: global disable overrides speculative
  wire [1:0] mode = feat_lo_r[`WOM_FEAT_GLOB] ? `WOM_MODE_NONE :
    (feat_lo_r[`WOM_FEAT_SPEC] ? `WOM_MODE_SPEC : `WOM_MODE_FULL);

  // Memory type: uncached flag wins over combining flag
  wire r0_in = rng_in(rng0_r, rq_addr_r);
  wire r1_in = rng_in(rng1_r, rq_addr_r);
  wire rq_unc = (r0_in & rng0_r[`WOM_RNG_NOCACHE]) | (r1_in & rng1_r[`WOM_RNG_NOCACHE]);
  wire rq_combr = (r0_in & rng0_r[`WOM_RNG_COMB]) | (r1_in & rng1_r[`WOM_RNG_COMB]);
  wire rq_is_wb = rq_kind_r == `WOM_KIND_WBACK;
  wire rq_ncache = ~rq_is_wb & (rq_unc | rq_combr);
  wire rq_comb = rq_ncache & ~rq_unc;
  wire rq_commit = ~rq_is_wb & ~rq_ncache & rq_hit_r & wb_line(rq_state_r);
  wire mb_match = mb_valid_r & (mb_addr_r == rq_addr_r[31:3]);
  // Writeback-state commits may pass the merge buffer except in full mode
  wire need_drain = mb_valid_r & ~(rq_comb & mb_match) &
    ~(rq_commit & (mode != `WOM_MODE_FULL));
  wire hold = bufemp_neg_r & (mode != `WOM_MODE_NONE);
  // Store addresses pass the tags, so bit 20 is masked there only
  wire [31:0] in_addr = (wr_kind == `WOM_KIND_STORE) ?
    {wr_addr[31:21], wr_addr[`WOM_A20_BIT] & ~a20_act_r, wr_addr[19:0]} : wr_addr;
  wire addr_ok = (paddr == `WOM_ADDR_FEAT_LO) || (paddr == `WOM_ADDR_FEAT_HI) ||
    (paddr == `WOM_ADDR_RANGE0) || (paddr == `WOM_ADDR_RANGE1) ||
    (paddr == `WOM_ADDR_STATUS);

  always @*
  begin
    case (paddr)
      `WOM_ADDR_FEAT_LO: rd_val = feat_lo_r;
      `WOM_ADDR_FEAT_HI: rd_val = feat_hi_r;
      `WOM_ADDR_RANGE0: rd_val = rng0_r;
      `WOM_ADDR_RANGE1: rd_val = rng1_r;
      `WOM_ADDR_STATUS: rd_val = {24'h000000, st_r, a20_act_r, bufemp_neg_r, wr_held_r,
        mb_valid_r, mode};
      default: rd_val = 32'h00000000;
    endcase
  end

  // APB slave, one access cycle
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      feat_lo_r <= `WOM_FEAT_RST;
      feat_hi_r <= `WOM_FEAT_RST;
      rng0_r <= `WOM_RANGE_RST;
      rng1_r <= `WOM_RANGE_RST;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~addr_ok;
      if (psel & ~penable & ~pready)
        prdata <= pwrite ? 32'h00000000 : rd_val;
      if (psel & penable & pready & pwrite)
      begin
        case (paddr)
          `WOM_ADDR_FEAT_LO: feat_lo_r <= pwdata;
          `WOM_ADDR_FEAT_HI: feat_hi_r <= pwdata;
          `WOM_ADDR_RANGE0: rng0_r <= pwdata;
          `WOM_ADDR_RANGE1: rng1_r <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // Pin synchronisers; a change counts when stages two and three agree
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      a20_sy_r <= 3'h7;
      bufemp_sy_r <= 3'h0;
      a20_act_r <= 1'b0;
      bufemp_neg_r <= 1'b0;
    end
    else
    begin
      a20_sy_r <= {a20_sy_r[1:0], addr_bit20_mask_n};
      bufemp_sy_r <= {bufemp_sy_r[1:0], ext_write_buf_empty_n};
      if (a20_sy_r[1] == a20_sy_r[2])
        a20_act_r <= ~a20_sy_r[2];
      if (bufemp_sy_r[1] == bufemp_sy_r[2])
        bufemp_neg_r <= bufemp_sy_r[2];
    end
  end

  // Write sequencer
  always @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_r <= ST_IDLE;
      drain_ret_r <= 1'b0;
      rq_kind_r <= `WOM_KIND_STORE;
      rq_addr_r <= 32'h00000000;
      rq_data_r <= 64'h0000000000000000;
      rq_be_r <= 8'h00;
      rq_hit_r <= 1'b0;
      rq_state_r <= `WOM_MESI_I;
      mb_valid_r <= 1'b0;
      mb_addr_r <= 29'h00000000;
      mb_data_r <= 64'h0000000000000000;
      mb_be_r <= 8'h00;
      wr_done_r <= 1'b0;
      wr_held_r <= 1'b0;
      bus_req_r <= 1'b0;
      bus_burst_r <= 1'b0;
      bus_addr_r <= 32'h00000000;
      bus_data_r <= 64'h0000000000000000;
      bus_be_r <= 8'h00;
      cache_commit_r <= 1'b0;
      cache_addr_r <= 32'h00000000;
      cache_data_r <= 64'h0000000000000000;
      cache_be_r <= 8'h00;
    end
    else
    begin
      wr_done_r <= 1'b0;
      cache_commit_r <= 1'b0;
      case (st_r)
        ST_IDLE:
        begin
          if (wr_valid & ~wr_done_r)
          begin
            rq_kind_r <= wr_kind;
            rq_addr_r <= in_addr;
            rq_data_r <= wr_data;
            rq_be_r <= wr_be;
            rq_hit_r <= wr_hit;
            rq_state_r <= wr_state;
            st_r <= ST_DECIDE;
          end
          else if (mb_valid_r)
          begin
            // Idle drain of combined data as one single cycle
            bus_req_r <= 1'b1;
            bus_burst_r <= 1'b0;
            bus_addr_r <= {mb_addr_r, 3'h0};
            bus_data_r <= mb_data_r;
            bus_be_r <= mb_be_r;
            drain_ret_r <= 1'b0;
            st_r <= ST_DRAIN;
          end
        end
        ST_DECIDE:
        begin
          if (need_drain)
          begin
            bus_req_r <= 1'b1;
            bus_burst_r <= 1'b0;
            bus_addr_r <= {mb_addr_r, 3'h0};
            bus_data_r <= mb_data_r;
            bus_be_r <= mb_be_r;
            drain_ret_r <= 1'b1;
            st_r <= ST_DRAIN;
          end
          else if (rq_comb)
          begin
            mb_valid_r <= 1'b1;
            mb_addr_r <= rq_addr_r[31:3];
            mb_data_r <= merge_bytes(mb_match ? mb_data_r : 64'h0000000000000000,
              rq_data_r, rq_be_r);
            mb_be_r <= (mb_match ? mb_be_r : 8'h00) | rq_be_r;
            wr_done_r <= 1'b1;
            st_r <= ST_IDLE;
          end
          else if (rq_commit)
          begin
            wr_held_r <= hold;
            if (~hold)
            begin
              // Writeback-state line: cache only, gated by buffer-empty except in mode none
              cache_commit_r <= 1'b1;
              cache_addr_r <= rq_addr_r;
              cache_data_r <= rq_data_r;
              cache_be_r <= rq_be_r;
              wr_done_r <= 1'b1;
              st_r <= ST_IDLE;
            end
          end
          else
          begin
            bus_req_r <= 1'b1;
            bus_burst_r <= rq_is_wb;
            bus_addr_r <= rq_addr_r;
            bus_data_r <= rq_data_r;
            bus_be_r <= rq_is_wb ? 8'hff : rq_be_r;
            st_r <= ST_BUS;
          end
        end
        ST_DRAIN:
        begin
          if (bus_ack)
          begin
            bus_req_r <= 1'b0;
            mb_valid_r <= 1'b0;
            mb_be_r <= 8'h00;
            st_r <= drain_ret_r ? ST_DECIDE : ST_IDLE;
          end
        end
        ST_BUS:
        begin
          if (bus_ack)
          begin
            bus_req_r <= 1'b0;
            bus_burst_r <= 1'b0;
            // Writethrough hit updates the cache with the bus cycle
            if (~rq_is_wb & ~rq_ncache & rq_hit_r)
            begin
              cache_commit_r <= 1'b1;
              cache_addr_r <= rq_addr_r;
              cache_data_r <= rq_data_r;
              cache_be_r <= rq_be_r;
            end
            wr_done_r <= 1'b1;
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

endmodule // wom_ctrl

//--- tb/wom_monitor.sv
`timescale 1ns/1ps
module wom_monitor (
  input wire clock, // Clock
  input wire sys_rst, // Reset
  input wire psel, // Select
  input wire penable, // Enable
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire wr_valid, // Request
  input wire wr_kind, // Kind
  input wire [31:0] wr_addr, // Address
  input wire wr_done_r, // Done
  input wire wr_held_r, // Held
  input wire bus_req_r, // Bus request
  input wire bus_burst_r, // Burst
  input wire [31:0] bus_addr_r, // Bus address
  input wire [7:0] bus_be_r, // Bus lanes
  input wire bus_ack, // Bus done
  input wire cache_commit_r // Commit
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    pready && psel && penable;
  endsequence
  a_apb_answer: assert property (s_setup |=> s_access ##1 !pready)
    else $error("apb answer late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_done_pulse: assert property (wr_done_r |=> !wr_done_r)
    else $error("done too long");
  a_bus_stable: assert property (bus_req_r && !bus_ack |=> bus_req_r && $stable(bus_addr_r))
    else $error("bus request moved");
  a_burst_wback: assert property (bus_req_r && bus_burst_r |-> wr_kind && bus_be_r == 8'hff)
    else $error("burst not writeback");
  a_store_single: assert property (bus_req_r && wr_valid && !wr_kind |-> !bus_burst_r)
    else $error("store as burst");
  a_wback_nomask: assert property (bus_burst_r && bus_req_r |-> bus_addr_r[20] == wr_addr[20])
    else $error("writeback masked");
  a_held_nocommit: assert property (wr_held_r |-> !cache_commit_r)
    else $error("commit while held");
  a_done_bound: assert property ($rose(wr_valid) |-> ##[1:400] wr_done_r)
    else $error("request never done");
endmodule // wom_monitor
bind wom_ctrl wom_monitor i_mon (.clock(clock), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .wr_valid(wr_valid),
  .wr_kind(wr_kind), .wr_addr(wr_addr), .wr_done_r(wr_done_r), .wr_held_r(wr_held_r),
  .bus_req_r(bus_req_r), .bus_burst_r(bus_burst_r), .bus_addr_r(bus_addr_r),
  .bus_be_r(bus_be_r), .bus_ack(bus_ack), .cache_commit_r(cache_commit_r));

//--- tb/wom_far_model.sv
`timescale 1ns/1ps
module wom_far_model (
  input wire clock, // Clock
  input wire sys_rst, // Reset
  input wire bus_req_r, // Bus request
  output reg bus_ack, // Cycle done
  output wire buf_empty_n // Buffer-empty, low active
);
  reg [4:0] cnt_r;
  reg [4:0] hold_r;
  reg slow_r;
  // Alternate prompt and slow answers
  always @(posedge clock)
  begin
    bus_ack <= 1'b0;
    if (sys_rst)
    begin
      cnt_r <= 5'h00;
      slow_r <= 1'b0;
      hold_r <= 5'h00;
    end
    else
    begin
      hold_r <= bus_req_r ? 5'h14 : (hold_r != 5'h00) ? hold_r - 5'h01 : 5'h00;
      if (bus_req_r && !bus_ack)
      begin
        cnt_r <= cnt_r + 5'h01;
        if (cnt_r >= (slow_r ? 5'h06 : 5'h00))
        begin
          bus_ack <= 1'b1;
          cnt_r <= 5'h00;
          slow_r <= !slow_r;
        end
      end
    end
  end
  assign buf_empty_n = bus_req_r || (hold_r != 5'h00);
endmodule // wom_far_model

//--- tb/tb_write_order_merge_ctrl.sv
`timescale 1ns/1ps
module tb_write_order_merge_ctrl;
  reg clock = 1'b0;
  reg sys_rst = 1'b1;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, a20_n = 1'b1, wr_valid = 1'b0;
  reg wr_kind = 1'b0, wr_hit = 1'b0, e, saw_held;
  reg [1:0] wr_state = 2'h0, md;
  reg [7:0] wr_be = 8'h00;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, wr_addr = 32'h0, seed = 32'hf1e83211, rd, a;
  reg [63:0] wr_data = 64'h0;
  reg [41:0] exp_q[$];
  wire pready, pslverr, done, held, breq, burst, ack, buf_empty_n, commit;
  wire [7:0] bbe, cbe;
  wire [31:0] prdata, baddr, caddr;
  integer err_total = 0, comparisons = 0, i, n;
  always #4 clock = ~clock;
  wom_ctrl i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .addr_bit20_mask_n(a20_n), .ext_write_buf_empty_n(buf_empty_n),
    .wr_valid(wr_valid), .wr_kind(wr_kind), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_be(wr_be), .wr_hit(wr_hit), .wr_state(wr_state), .wr_done_r(done),
    .wr_held_r(held), .bus_req_r(breq), .bus_burst_r(burst), .bus_addr_r(baddr),
    .bus_data_r(), .bus_be_r(bbe), .bus_ack(ack), .cache_commit_r(commit),
    .cache_addr_r(caddr), .cache_data_r(), .cache_be_r(cbe));
  wom_far_model i_far (.clock(clock), .sys_rst(sys_rst), .bus_req_r(breq),
    .bus_ack(ack), .buf_empty_n(buf_empty_n));
  function [31:0] xs(input [31:0] v);
    reg [31:0] t;
  begin
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  end
  endfunction
  task final_report(input to);
  begin
    if (to)
      err_total = err_total + 1;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task check(input [41:0] seen, input [41:0] want);
  begin
    comparisons = comparisons + 1;
    if (seen !== want)
    begin
      err_total = err_total + 1;
      $display("ERROR %0t: got %h want %h", $time, seen, want);
    end
  end
  endtask
  task apb(input wr, input [11:0] ad, input [31:0] d, output [31:0] q, output er);
  begin
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50)
    begin
      n = n + 1;
      @(posedge clock);
    end
    if (n == 50)
      final_report(1'b1);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task req(input k, input [31:0] ad, input [7:0] be, input [1:0] st);
  begin
    seed = xs(seed);
    @(posedge clock);
    wr_valid <= 1'b1;
    wr_kind <= k;
    wr_addr <= ad;
    wr_be <= be;
    wr_hit <= st != 2'h0;
    wr_state <= st;
    wr_data <= {seed, ~seed};
    saw_held = 1'b0;
    n = 0;
    @(posedge clock);
    while (done !== 1'b1 && n < 500)
    begin
      saw_held = saw_held | (held === 1'b1);
      n = n + 1;
      @(posedge clock);
    end
    if (n == 500)
      final_report(1'b1);
    wr_valid <= 1'b0;
  end
  endtask
  task got(input [41:0] v);
  begin
    if (exp_q.size() == 0)
      check(v, 42'h3ffffffffff);
    else
      check(v, exp_q.pop_front());
  end
  endtask
  always @(posedge clock)
  begin
    if (!sys_rst && breq === 1'b1 && ack === 1'b1)
      got({burst ? 2'h2 : 2'h1, bbe, baddr});
    if (!sys_rst && commit === 1'b1)
      got({2'h3, cbe, caddr});
  end
  initial
  begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    apb(1'b0, 12'h000, 32'h0, rd, e);
    check({10'h0, rd}, 42'h0);
    apb(1'b0, 12'hffc, 32'h0, rd, e);
    check({9'h0, e, rd}, {10'h1, 32'h0});
    for (i = 0; i < 4; i = i + 1)
    begin
      md = (i == 0) ? 2'h2 : (i == 1) ? 2'h1 : 2'h0;
      apb(1'b1, 12'h000, i * 4, rd, e);
      apb(1'b0, 12'h010, 32'h0, rd, e);
      check({40'h0, rd[1:0]}, {40'h0, md});
      a = {12'h0, seed[19:3], 3'h0};
      exp_q.push_back({2'h1, 8'h0f, a});
      exp_q.push_back({2'h3, 8'h0f, a});
      req(1'b0, a, 8'h0f, 2'h1);
      exp_q.push_back({2'h3, 8'hf0, a ^ 32'h40});
      req(1'b0, a ^ 32'h40, 8'hf0, 2'h2);
      check({41'h0, saw_held}, {41'h0, md != 2'h0});
    end
    a20_n <= 1'b0;
    repeat (4) @(posedge clock);
    exp_q.push_back({2'h1, 8'h3c, a});
    exp_q.push_back({2'h3, 8'h3c, a});
    req(1'b0, a | 32'h00100000, 8'h3c, 2'h1);
    exp_q.push_back({2'h2, 8'hff, a | 32'h00100000});
    req(1'b1, a | 32'h00100000, 8'hff, 2'h3);
    a20_n <= 1'b1;
    apb(1'b1, 12'h008, 32'h4001fffe, rd, e);
    apb(1'b1, 12'h00c, 32'h6001ffff, rd, e);
    exp_q.push_back({2'h1, 8'h0f, 32'h40000008});
    exp_q.push_back({2'h1, 8'h3c, 32'h60000010});
    req(1'b0, 32'h40000008, 8'h0f, 2'h0);
    req(1'b0, 32'h60000010, 8'h3c, 2'h0);
    n = 0;
    while (exp_q.size() > 0 && n < 200)
    begin
      n = n + 1;
      @(posedge clock);
    end
    final_report(exp_q.size() > 0);
  end
endmodule // tb_write_order_merge_ctrl
